/* File: bsavd_pkg.sv */
// package of constants and carriers for the strap address/vector decode front end,
// plus the two-flop pin synchroniser that the front end instantiates.
// assumes one clock core_clk, asynchronous active-low reset, and a clock enable.
package bsavd_pkg;
  // ****************************************
  // strap banks
  // ****************************************
  localparam int ADDR_STRAP_N   = 10;   // address straps, first one on bit 12
  localparam int VEC_STRAP_N    = 10;   // vector bank positions 1..10
  localparam int ADDR_W         = 17;   // backplane address width
  localparam int ADDR_TOP_MSB   = 16;   // fixed all-ones field
  localparam int ADDR_TOP_LSB   = 13;
  localparam int ADDR_STRAP_MSB = 12;   // strap index 0 compares this bit
  localparam int WORD_MSB       = 3;    // word select within eight-word block
  localparam int WORD_LSB       = 1;
  localparam int WORD_W         = 3;
  localparam int VEC_W          = 9;    // vector bits 8..0
  localparam int VEC_LSB        = 3;    // lowest strap-driven vector bit
  localparam int VEC_POS_LSB    = 6;    // position that drives VEC_LSB
  localparam int POS_UNUSED     = 7;    // positions are numbered from 1
  localparam int POS_OSC        = 8;
  localparam int POS_HALT       = 9;
  localparam int POS_BOOT       = 10;

  // ****************************************
  // software register port
  // ****************************************
  localparam int                RA_W       = 3;
  localparam int                RD_W       = 16;
  localparam logic [RA_W-1:0]   REG_STATUS = 3'h0;
  localparam logic [RA_W-1:0]   REG_CTRL   = 3'h1;
  localparam int                ST_OSC     = 9;
  localparam int                ST_HALT    = 10;
  localparam int                ST_BOOT    = 11;
  localparam int                ST_ILLEGAL = 12;
  localparam int                ST_SEEN    = 13;
  localparam int                CT_BRK_EN  = 0;
  localparam logic              CT_BRK_EN_RST = 1'b1;

  typedef struct packed {
    logic              valid;            // address strobe from backplane
    logic [ADDR_W-1:0] addr;             // byte address
  } bsavd_addr_s;

  typedef struct packed {
    logic iak;                           // interrupt acknowledge chain
    logic dmg;                           // dma grant chain
  } bsavd_chain_s;
endpackage : bsavd_pkg

`timescale 1ns/1ps
module bsavd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,  // core clock
  input  wire logic             arst_n,    // async reset, active low
  input  wire logic             ce,        // clock enable
  input  wire logic [WIDTH-1:0] d,         // asynchronous input
  output logic      [WIDTH-1:0] q          // synchronised output
);
  // ****************************************
  // two flops, first one read only by the second
  // ****************************************
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] q_d;

  // refuse an empty synchroniser while elaborating, not at run time
  if (WIDTH < 1) begin : g_bad_width
    $error("bsavd_sync: WIDTH must be at least 1");
  end

  // next values, held while ce is low
  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d    = ce ? meta_q : q;
  end

  // registers only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= meta_d;
      q      <= q_d;
    end
  end
endmodule : bsavd_sync

/* File: bsavd_top.sv */
// strap-configured bus front end: address match, vector, oscillator gate,
// line-3 break action and the daisy-chain pass-through.
// assumes straps and backplane signals are asynchronous pins; break and
// oscillator tick come from logic on core_clk.
`timescale 1ns/1ps
//
// Contract
// R1: closed address strap needs a 1, open a 0; strap 1 is bit 12 downward.
// R2: vector position 6 drives bit 3, position 5 bit 4, upward; closed is 1.
// R3: vector position 7 is ignored entirely.
// R4: open position 8 cuts the baud oscillator off from all circuitry.
// R5: break on line 3: straps 9/10 give none, halt, boot; both closed illegal.
// R6: interrupt-acknowledge and dma-grant chain signals pass through to the next slot.
// R7: respond only when bits 16..13 are ones and straps match; bits 3..1 pick word.
module bsavd_top (
  input  wire logic                             core_clk,      // 40 MHz core clock
  input  wire logic                             arst_n,        // async reset, active low
  input  wire logic                             ce,            // clock enable, freezes state
  input  wire logic [bsavd_pkg::ADDR_STRAP_N-1:0] addr_strap,  // address straps, 1 = closed
  input  wire logic [bsavd_pkg::VEC_STRAP_N-1:0]  vec_strap,   // vector bank, bit 0 = pos 1
  input  wire bsavd_pkg::bsavd_addr_s           bus_in,        // backplane address pins
  input  wire bsavd_pkg::bsavd_chain_s          chain_in,      // chain from previous slot
  input  wire logic                             osc_tick,      // internal baud oscillator tick
  input  wire logic                             line3_break,   // break seen on line 3, pulse
  input  wire logic [bsavd_pkg::RA_W-1:0]       reg_addr,      // register index
  input  wire logic [bsavd_pkg::RD_W-1:0]       reg_wdata,     // write data
  input  wire logic                             reg_wr,        // write strobe
  input  wire logic                             reg_rd,        // read strobe
  output logic      [bsavd_pkg::RD_W-1:0]       reg_rdata,     // read data, cycle after strobe
  output logic                                  dev_sel_q,     // address hits this device
  output logic      [bsavd_pkg::WORD_W-1:0]     word_q,        // selected word register
  output logic      [bsavd_pkg::VEC_W-1:0]      vector_q,      // interrupt vector
  output logic                                  osc_tick_q,    // gated oscillator tick
  output logic                                  halt_req_q,    // processor halt request, pulse
  output logic                                  boot_req_q,    // processor boot request, pulse
  output bsavd_pkg::bsavd_chain_s               chain_out      // chain to next slot
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int SYNC_W = bsavd_pkg::ADDR_STRAP_N + bsavd_pkg::VEC_STRAP_N + bsavd_pkg::ADDR_W + 3;

  logic [bsavd_pkg::ADDR_STRAP_N-1:0] addr_s;
  logic [bsavd_pkg::VEC_STRAP_N-1:0]  vec_s;
  bsavd_pkg::bsavd_addr_s             bus_s;
  bsavd_pkg::bsavd_chain_s            chain_s;

  bsavd_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .d        ({addr_strap, vec_strap, bus_in, chain_in}),
    .q        ({addr_s, vec_s, bus_s, chain_s})
  );

  // strap position p (1-based) as a level
  function automatic logic pos(input logic [bsavd_pkg::VEC_STRAP_N-1:0] v, input int p);
    pos = v[p-1];
  endfunction : pos

  // ****************************************
  // address compare and vector forming
  // ****************************************
  logic [bsavd_pkg::ADDR_STRAP_N-1:0] strap_hit;
  logic [bsavd_pkg::VEC_W-1:0]        vec_d;
  logic                               match;

  // each strap demands its own level on one address bit
  genvar gi;
  generate
    for (gi = 0; gi < bsavd_pkg::ADDR_STRAP_N; gi++) begin : g_addr
      assign strap_hit[gi] = bus_s.addr[bsavd_pkg::ADDR_STRAP_MSB-gi] == addr_s[gi]; // R1
    end
    // vector bit VEC_LSB+k is driven by position VEC_POS_LSB-k
    for (gi = 0; gi < bsavd_pkg::VEC_W; gi++) begin : g_vec
      if (gi < bsavd_pkg::VEC_LSB) begin : g_zero
        assign vec_d[gi] = 1'b0;
      end else begin : g_strap
        assign vec_d[gi] = vec_s[bsavd_pkg::VEC_POS_LSB-1-(gi-bsavd_pkg::VEC_LSB)]; // R2 R3
      end
    end
  endgenerate

  // top field all ones plus every strap bit agreeing
  assign match = bus_s.valid && (&bus_s.addr[bsavd_pkg::ADDR_TOP_MSB:bsavd_pkg::ADDR_TOP_LSB])
                 && (&strap_hit); // R7

  // ****************************************
  // break action decode
  // ****************************************
  logic halt_sel;
  logic boot_sel;
  logic illegal;

  // both straps closed is illegal and therefore acts as no action
  assign halt_sel = pos(vec_s, bsavd_pkg::POS_HALT) && !pos(vec_s, bsavd_pkg::POS_BOOT); // R5
  assign boot_sel = pos(vec_s, bsavd_pkg::POS_BOOT) && !pos(vec_s, bsavd_pkg::POS_HALT); // R5
  assign illegal  = pos(vec_s, bsavd_pkg::POS_HALT) && pos(vec_s, bsavd_pkg::POS_BOOT);

  // ****************************************
  // datapath registers
  // ****************************************
  logic                           dev_sel_d;
  logic [bsavd_pkg::WORD_W-1:0]   word_d;
  logic [bsavd_pkg::VEC_W-1:0]    vector_d;
  logic                           osc_tick_d;
  logic                           halt_req_d;
  logic                           boot_req_d;
  bsavd_pkg::bsavd_chain_s        chain_d;
  logic                           brk_en_q;
  logic                           brk_en_d;
  logic                           seen_q;
  logic                           seen_d;
  logic [bsavd_pkg::RD_W-1:0]     rdata_d;
  logic                           brk_go;

  assign brk_go = line3_break && brk_en_q;

  // next values; ce low holds everything so the block freezes cleanly
  always_comb begin
    dev_sel_d  = dev_sel_q;
    word_d     = word_q;
    vector_d   = vector_q;
    osc_tick_d = osc_tick_q;
    halt_req_d = halt_req_q;
    boot_req_d = boot_req_q;
    chain_d    = chain_out;
    brk_en_d   = brk_en_q;
    seen_d     = seen_q;
    rdata_d    = reg_rdata;
    if (ce) begin
      dev_sel_d  = match; // R7
      word_d     = match ? bus_s.addr[bsavd_pkg::WORD_MSB:bsavd_pkg::WORD_LSB] : word_q; // R7
      vector_d   = vec_d; // R2
      osc_tick_d = osc_tick && pos(vec_s, bsavd_pkg::POS_OSC); // R4
      halt_req_d = brk_go && halt_sel; // R5
      boot_req_d = brk_go && boot_sel; // R5
      chain_d    = chain_s; // R6
      rdata_d    = '0;
      if (reg_wr && reg_addr == bsavd_pkg::REG_CTRL) begin
        brk_en_d = reg_wdata[bsavd_pkg::CT_BRK_EN];
      end
      // write-one-to-clear, but a break in the same cycle wins
      if (reg_wr && reg_addr == bsavd_pkg::REG_STATUS && reg_wdata[bsavd_pkg::ST_SEEN]) begin
        seen_d = 1'b0;
      end
      if (line3_break) begin
        seen_d = 1'b1;
      end
      if (reg_rd) begin
        case (reg_addr)
          bsavd_pkg::REG_STATUS: begin
            rdata_d[bsavd_pkg::VEC_W-1:0]  = vector_q;
            rdata_d[bsavd_pkg::ST_OSC]     = pos(vec_s, bsavd_pkg::POS_OSC);
            rdata_d[bsavd_pkg::ST_HALT]    = halt_sel;
            rdata_d[bsavd_pkg::ST_BOOT]    = boot_sel;
            rdata_d[bsavd_pkg::ST_ILLEGAL] = illegal;
            rdata_d[bsavd_pkg::ST_SEEN]    = seen_q;
          end
          bsavd_pkg::REG_CTRL: begin
            rdata_d[bsavd_pkg::CT_BRK_EN]  = brk_en_q;
          end
          default: begin
            rdata_d = '0;
          end
        endcase
      end
    end
  end

  // registers only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_sel_q  <= 1'b0;
      word_q     <= '0;
      vector_q   <= '0;
      osc_tick_q <= 1'b0;
      halt_req_q <= 1'b0;
      boot_req_q <= 1'b0;
      chain_out  <= '0;
      brk_en_q   <= bsavd_pkg::CT_BRK_EN_RST;
      seen_q     <= 1'b0;
      reg_rdata  <= '0;
    end else begin
      dev_sel_q  <= dev_sel_d;
      word_q     <= word_d;
      vector_q   <= vector_d;
      osc_tick_q <= osc_tick_d;
      halt_req_q <= halt_req_d;
      boot_req_q <= boot_req_d;
      chain_out  <= chain_d;
      brk_en_q   <= brk_en_d;
      seen_q     <= seen_d;
      reg_rdata  <= rdata_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_break_halt;
    ce && line3_break && brk_en_q && halt_sel;
  endsequence
  sequence s_break_boot;
    ce && line3_break && brk_en_q && boot_sel;
  endsequence

  property p_addr_strap;
    @(posedge core_clk) disable iff (!arst_n)
      $past(ce) && dev_sel_q |-> $past(bus_s.addr[bsavd_pkg::ADDR_STRAP_MSB]) == $past(addr_s[0]);
  endproperty
  a_addr_strap: assert property (p_addr_strap) else $error("address strap mismatch accepted"); // R1

  property p_vec_bit;
    @(posedge core_clk) disable iff (!arst_n)
      $past(ce) |-> vector_q[bsavd_pkg::VEC_LSB] == $past(vec_s[bsavd_pkg::VEC_POS_LSB-1])
                    && vector_q[bsavd_pkg::VEC_LSB+1] == $past(vec_s[bsavd_pkg::VEC_POS_LSB-2])
                    && vector_q[bsavd_pkg::VEC_LSB-1:0] == '0;
  endproperty
  a_vec_bit: assert property (p_vec_bit) else $error("vector bit not driven by its strap"); // R2

  property p_unused_pos;
    @(posedge core_clk) disable iff (!arst_n)
      ce && $past(ce) && (($past(vec_s) ^ vec_s) == (1 << (bsavd_pkg::POS_UNUSED-1))) |=> $stable(vector_q);
  endproperty
  a_unused_pos: assert property (p_unused_pos) else $error("unused position changed the vector"); // R3

  property p_osc_cut;
    @(posedge core_clk) disable iff (!arst_n)
      $past(ce) && !$past(vec_s[bsavd_pkg::POS_OSC-1]) |-> !osc_tick_q;
  endproperty
  a_osc_cut: assert property (p_osc_cut) else $error("oscillator tick passed with test strap open"); // R4

  property p_break_act;
    @(posedge core_clk) disable iff (!arst_n)
      (s_break_halt |=> halt_req_q && !boot_req_q) and (s_break_boot |=> boot_req_q && !halt_req_q);
  endproperty
  a_break_act: assert property (p_break_act) else $error("break action wrong"); // R5

  property p_break_illegal;
    @(posedge core_clk) disable iff (!arst_n)
      $past(ce) && (halt_req_q || boot_req_q) |-> $past(line3_break) && !$past(illegal) && $past(brk_en_q);
  endproperty
  a_break_illegal: assert property (p_break_illegal) else $error("request without legal break"); // R5

  property p_chain;
    @(posedge core_clk) disable iff (!arst_n)
      $past(ce) |-> chain_out == $past(chain_s);
  endproperty
  a_chain: assert property (p_chain) else $error("chain signal not passed on"); // R6

  property p_top_word;
    @(posedge core_clk) disable iff (!arst_n)
      $past(ce) && dev_sel_q |-> (&$past(bus_s.addr[bsavd_pkg::ADDR_TOP_MSB:bsavd_pkg::ADDR_TOP_LSB]))
                                 && word_q == $past(bus_s.addr[bsavd_pkg::WORD_MSB:bsavd_pkg::WORD_LSB]);
  endproperty
  a_top_word: assert property (p_top_word) else $error("selected outside top space or wrong word"); // R7
endmodule : bsavd_top

/* File: bsavd_host.sv */
// host side model: places the backplane address and the grant chain pins.
// assumes the bench hands it requests on core_clk, changed just after an edge.
`timescale 1ns/1ps
module bsavd_host (
  input  wire logic                         core_clk,  // core clock
  input  wire logic                         req_on,    // host addresses the bus
  input  wire logic [bsavd_pkg::ADDR_W-1:0] req_addr,  // byte address to place
  input  wire bsavd_pkg::bsavd_chain_s      req_chain, // grants sent down the chain
  output bsavd_pkg::bsavd_addr_s            bus_in,    // address pins
  output bsavd_pkg::bsavd_chain_s           chain_in   // chain pins
);
  // ****************************************
  // pin drivers
  // ****************************************
  // a released bus shows the inverse of the last address so a stale one never looks valid
  always_ff @(posedge core_clk) begin
    bus_in.valid <= req_on;
    bus_in.addr  <= req_on ? req_addr : ~req_addr;
    chain_in     <= req_chain;
  end
endmodule : bsavd_host

/* File: test_bsavd_top.sv */
// self-checking bench for the strap decode front end.
// assumes the host model drives the backplane pins; ce is dropped once to check freezing.
`timescale 1ns/1ps
module test_bsavd_top;
  // ****************************************
  // signals and instances
  // ****************************************
  logic                    core_clk    = 1'b0;
  logic                    arst_n      = 1'b0;
  logic                    ce          = 1'b1;
  logic [9:0]              addr_strap  = 10'h000;
  logic [9:0]              vec_strap   = 10'h080;
  logic                    osc_tick    = 1'b0;
  logic                    line3_break = 1'b0;
  logic [2:0]              reg_addr    = 3'h0;
  logic [15:0]             reg_wdata   = 16'h0000;
  logic                    reg_wr      = 1'b0;
  logic                    reg_rd      = 1'b0;
  logic                    req_on      = 1'b0;
  logic [16:0]             req_addr    = 17'h00000;
  bsavd_pkg::bsavd_chain_s req_chain   = 2'h0;
  bsavd_pkg::bsavd_addr_s  bus_in;
  bsavd_pkg::bsavd_chain_s chain_in;
  bsavd_pkg::bsavd_chain_s chain_out;
  logic [15:0]             reg_rdata;
  logic                    dev_sel_q;
  logic [2:0]              word_q;
  logic [8:0]              vector_q;
  logic                    osc_tick_q;
  logic                    halt_req_q;
  logic                    boot_req_q;
  logic [16:0]             a;
  logic [7:0]              pat [4] = '{8'ha5, 8'he5, 8'h5a, 8'hda};
  int                      n_fail = 0;
  int                      num_checks = 0;

  // half period of the 25 ns clock
  always #12.5 core_clk = ~core_clk;

  bsavd_host u_bsavd_host (.core_clk(core_clk), .req_on(req_on), .req_addr(req_addr),
    .req_chain(req_chain), .bus_in(bus_in), .chain_in(chain_in));
  bsavd_top u_bsavd_top (.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .addr_strap(addr_strap),
    .vec_strap(vec_strap), .bus_in(bus_in), .chain_in(chain_in), .osc_tick(osc_tick),
    .line3_break(line3_break), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_sel_q(dev_sel_q), .word_q(word_q),
    .vector_q(vector_q), .osc_tick_q(osc_tick_q), .halt_req_q(halt_req_q),
    .boot_req_q(boot_req_q), .chain_out(chain_out));

  // ****************************************
  // helpers
  // ****************************************
  // expected vector: position 6 lands on bit 3, moving up as positions go down
  function automatic logic [8:0] vexp(input logic [9:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int k = 0; k < 6; k++) r[3+k] = v[5-k];
    return r;
  endfunction : vexp

  function automatic logic [15:0] stexp(input logic [9:0] v, input logic seen);
    return {2'b00, seen, v[9] & v[8], v[9] & ~v[8], v[8] & ~v[9], v[7], vexp(v)};
  endfunction : stexp

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [2:0] ad, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp, "register read");
  endtask : rdchk

  // synchroniser plus register is three edges; six leaves margin
  task automatic settle;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : settle

  // one-cycle pulses on the tick and break inputs, looked at in the answer cycle
  task automatic kick(input logic o, input logic b);
    @(posedge core_clk);
    osc_tick    <= o;
    line3_break <= b;
    @(posedge core_clk);
    osc_tick    <= 1'b0;
    line3_break <= 1'b0;
    #1;
  endtask : kick

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    settle;
    rdchk(3'h1, 16'h0001);
    wr(3'h5, 16'hffff);
    rdchk(3'h5, 16'h0000);
    $display("test registers done");
    @(posedge core_clk);
    addr_strap <= 10'h2a5;
    a = {4'hf, 13'h0006};
    for (int i = 0; i < 10; i++) a[12-i] = 10'h2a5 >> i;
    req_on   <= 1'b1;
    req_addr <= a;
    settle;
    chk(dev_sel_q, 1'b1, "select");
    chk(word_q, {1'b1, 2'b11}, "word");
    for (int j = 3; j < 14; j++) begin
      @(posedge core_clk);
      req_addr <= a ^ (17'h00001 << j);
      settle;
      chk(dev_sel_q, 1'b0, "mismatch");
    end
    @(posedge core_clk);
    req_addr <= a ^ 17'h00004;
    settle;
    chk({dev_sel_q, word_q}, 4'b1101, "second word");
    @(posedge core_clk);
    req_on <= 1'b0;
    settle;
    chk(dev_sel_q, 1'b0, "released");
    $display("test address done");
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      req_chain <= c[1:0];
      settle;
      chk(chain_out, c[1:0], "chain");
    end
    // ce low must freeze the whole pipe, synchronisers included
    @(posedge core_clk);
    ce        <= 1'b0;
    req_chain <= 2'h0;
    settle;
    chk(chain_out, 2'h3, "frozen");
    @(posedge core_clk);
    ce <= 1'b1;
    settle;
    chk(chain_out, 2'h0, "resumed");
    $display("test chain done");
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      vec_strap <= {s[1:0], pat[s]};
      settle;
      wr(3'h0, 16'h2000);
      chk(vector_q, vexp({s[1:0], pat[s]}), "vector");
      rdchk(3'h0, stexp({s[1:0], pat[s]}, 1'b0));
      kick(1'b1, 1'b1);
      chk({halt_req_q, boot_req_q}, {s == 1, s == 2}, "break");
      chk(osc_tick_q, pat[s][7], "osc gate");
      rdchk(3'h0, stexp({s[1:0], pat[s]}, 1'b1));
    end
    wr(3'h1, 16'h0000);
    @(posedge core_clk);
    vec_strap <= 10'h180;
    settle;
    wr(3'h0, 16'h2000);
    kick(1'b0, 1'b1);
    chk({halt_req_q, boot_req_q, osc_tick_q}, 3'b000, "disabled");
    rdchk(3'h0, stexp(10'h180, 1'b1));
    // only position 7 moves between these two settings
    @(posedge core_clk);
    vec_strap <= 10'h1a5;
    settle;
    @(posedge core_clk);
    vec_strap <= 10'h1e5;
    settle;
    chk(vector_q, vexp(10'h1a5), "unused position");
    $display("test vector and break done");
    print_verdict;
  end

  // the tests need well under 2000 cycles
  initial begin
    #200000;
    n_fail++;
    print_verdict;
  end
endmodule : test_bsavd_top
